// file: core/tls_pkg.sv
// ****************************************************************
// types and constants shared by the load/store unit
// ****************************************************************
package tls_pkg;

  typedef enum logic [1:0] {
    TLS_SZ_BYTE,
    TLS_SZ_HALF,
    TLS_SZ_WORD
  } tls_size_type;

  typedef enum logic [2:0] {
    TLS_OP_NONE,
    TLS_OP_SINGLE,
    TLS_OP_LIT,
    TLS_OP_MULTI,
    TLS_OP_PUSH,
    TLS_OP_POP
  } tls_op_type;

  // ****************************************************************
  // register indices, address steps
  // ****************************************************************
  localparam int          TLS_LIST_W     = 9;
  localparam logic [3:0]  TLS_SP_IDX     = 4'hd;
  localparam logic [3:0]  TLS_LR_IDX     = 4'he;
  localparam logic [3:0]  TLS_PC_IDX     = 4'hf;
  localparam logic [3:0]  TLS_EXTRA_BIT  = 4'h8;
  localparam logic [31:0] TLS_PC_AHEAD   = 32'h4;
  localparam logic [31:0] TLS_WORD_BYTES = 32'h4;

  // ****************************************************************
  // opcode patterns of the 16-bit instruction word
  // ****************************************************************
  localparam logic [4:0] TLS_ENC_LIT    = 5'h09;
  localparam logic [3:0] TLS_ENC_REGOFF = 4'h5;
  localparam logic [2:0] TLS_ENC_WB     = 3'h3;
  localparam logic [3:0] TLS_ENC_HALF   = 4'h8;
  localparam logic [3:0] TLS_ENC_SPREL  = 4'h9;
  localparam logic [3:0] TLS_ENC_MULTI  = 4'hc;
  localparam logic [6:0] TLS_ENC_PUSH   = 7'h5a;
  localparam logic [6:0] TLS_ENC_POP    = 7'h5e;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic         req;
    logic         write;
    tls_size_type size;
    logic [31:0]  addr;
    logic [31:0]  wdata;
  } tls_mem_req_type;

  typedef struct packed {
    logic        en;
    logic [3:0]  idx;
    logic [31:0] data;
  } tls_reg_wr_type;

  typedef struct packed {
    logic        en;
    logic [31:0] target;
    logic        tbit;
  } tls_branch_type;

  typedef struct packed {
    tls_op_type              op;
    logic                    load;
    logic                    sgn;
    tls_size_type            size;
    logic                    regoff;
    logic [2:0]              rt;
    logic [3:0]              rn;
    logic [2:0]              rm;
    logic [31:0]             imm;
    logic [TLS_LIST_W-1:0]   mask;
    logic                    wb;
  } tls_dec_type;

endpackage : tls_pkg

// file: core/tls_agu_ext.sv
`timescale 1ns/1ps
// ****************************************************************
// address sum, alignment check, store lane and load extension
// ****************************************************************
module tls_agu_ext (
  // address generation
  input  wire logic [31:0]          base,
  input  wire logic [31:0]          offset,
  input  wire tls_pkg::tls_size_type size,
  input  wire logic                 sgn,
  output logic      [31:0]          addr,
  output logic                      misaligned,
  // data shaping
  input  wire logic [31:0]          store_src,
  input  wire logic [31:0]          load_raw,
  output logic      [31:0]          store_data,
  output logic      [31:0]          load_data
);
  import tls_pkg::*;

  assign addr = base + offset;

  always_comb begin
    case (size)
      TLS_SZ_WORD: misaligned = addr[1:0] != 2'h0;
      TLS_SZ_HALF: misaligned = addr[0];
      default:     misaligned = 1'b0;
    endcase
  end

  always_comb begin
    case (size)
      TLS_SZ_BYTE: store_data = {24'h000000, store_src[7:0]};
      TLS_SZ_HALF: store_data = {16'h0000, store_src[15:0]};
      default:     store_data = store_src;
    endcase
  end

  always_comb begin
    case (size)
      TLS_SZ_BYTE:
        load_data = {{24{sgn & load_raw[7]}}, load_raw[7:0]};
      TLS_SZ_HALF:
        load_data = {{16{sgn & load_raw[15]}}, load_raw[15:0]};
      default:
        load_data = load_raw;
    endcase
  end

endmodule : tls_agu_ext

// file: core/tls_unit.sv
`timescale 1ns/1ps
// Overview of operation
// - stores write word, low byte or low halfword by access form
// - immediate address is base register plus unsigned immediate
// - stack-pointer word offsets 0..1020, eight-bit field times four
// - low-register word offsets 0..124, five-bit field times four
// - halfword offsets 0..62, five-bit field times two
// - byte offsets 0..31, five-bit field unscaled
// - single transfers select only the eight low registers
// - every single-transfer address checked against its access size
// - unaligned access is not performed and raises hard fault
// - no transfer changes the condition flags
// - loads write full word, zero- or sign-extended byte or halfword
// - register-offset address is base plus offset register
// - literal load fetches word-aligned word near the program counter
// - program counter reads as current instruction plus four
// - multiple transfer walks consecutive words from the base upward
// - lowest-numbered register goes to lowest address, ascending order
// - writeback stores base plus four times count into base
// - writeback always, except load whose list holds the base
// - push stores ending at sp minus four, sp gets lowest address
// - pop loads upward from sp, sp ends above highest word
// - pop of pc branches afterwards, bit zero sets state bit
// - push may add link register, pop may add program counter
module tls_unit (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // instruction stream
  input  wire logic                    instr_valid,
  input  wire logic [15:0]             instr,
  input  wire logic [31:0]             instr_pc,
  output logic                         instr_ready,
  output logic                         done,
  output logic                         fault,
  // register file
  output logic      [3:0]              reg_rd_idx,
  input  wire logic [31:0]             reg_rd_data,
  output tls_pkg::tls_reg_wr_type      reg_wr,
  output tls_pkg::tls_branch_type      branch,
  output logic                         flags_wr_en,
  // memory bus
  output tls_pkg::tls_mem_req_type     mem,
  input  wire logic                    mem_ack,
  input  wire logic [31:0]             mem_rdata
);
  import tls_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_BASE, ST_OFF, ST_ADDR, ST_DATA, ST_MEM, ST_WB
  } tls_state_type;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [3:0] count_regs(
    input logic [TLS_LIST_W-1:0] m);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < TLS_LIST_W; i++) begin
      n = n + {3'h0, m[i]};
    end
    return n;
  endfunction : count_regs

  // lowest listed bit, mapped to its register index
  function automatic logic [3:0] first_reg(
    input logic [TLS_LIST_W-1:0] m,
    input tls_op_type            op);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = TLS_LIST_W - 1; i >= 0; i--) begin
      if (m[i]) begin
        idx = i[3:0];
      end
    end
    if (idx == TLS_EXTRA_BIT) begin
      idx = (op == TLS_OP_PUSH) ? TLS_LR_IDX : TLS_PC_IDX;
    end
    return idx;
  endfunction : first_reg

  function automatic tls_dec_type decode(input logic [15:0] f);
    tls_dec_type d;
    d = '0;
    d.size = TLS_SZ_WORD;
    if (f[15:11] == TLS_ENC_LIT) begin
      d.op   = TLS_OP_LIT;
      d.load = 1'b1;
      d.rt   = f[10:8];
      d.imm  = {22'h000000, f[7:0], 2'h0};
    end else if (f[15:12] == TLS_ENC_REGOFF) begin
      d.op     = TLS_OP_SINGLE;
      d.regoff = 1'b1;
      d.rm     = f[8:6];
      d.rn     = {1'b0, f[5:3]};
      d.rt     = f[2:0];
      d.load   = f[11:9] >= 3'h3;
      d.sgn    = f[10:9] == 2'h3;
      case (f[10:9])
        2'h0:    d.size = TLS_SZ_WORD;
        2'h1:    d.size = f[11] ? TLS_SZ_HALF : TLS_SZ_HALF;
        2'h2:    d.size = TLS_SZ_BYTE;
        default: d.size = f[11] ? TLS_SZ_HALF : TLS_SZ_BYTE;
      endcase
    end else if (f[15:13] == TLS_ENC_WB) begin
      d.op   = TLS_OP_SINGLE;
      d.load = f[11];
      d.rn   = {1'b0, f[5:3]};
      d.rt   = f[2:0];
      d.size = f[12] ? TLS_SZ_BYTE : TLS_SZ_WORD;
      d.imm  = f[12] ? {27'h0000000, f[10:6]}
                     : {25'h0000000, f[10:6], 2'h0};
    end else if (f[15:12] == TLS_ENC_HALF) begin
      d.op   = TLS_OP_SINGLE;
      d.load = f[11];
      d.rn   = {1'b0, f[5:3]};
      d.rt   = f[2:0];
      d.size = TLS_SZ_HALF;
      d.imm  = {26'h0000000, f[10:6], 1'b0};
    end else if (f[15:12] == TLS_ENC_SPREL) begin
      d.op   = TLS_OP_SINGLE;
      d.load = f[11];
      d.rn   = TLS_SP_IDX;
      d.rt   = f[10:8];
      d.imm  = {22'h000000, f[7:0], 2'h0};
    end else if (f[15:12] == TLS_ENC_MULTI) begin
      d.op   = TLS_OP_MULTI;
      d.load = f[11];
      d.rn   = {1'b0, f[10:8]};
      d.mask = {1'b0, f[7:0]};
      d.wb   = !f[11] || !f[f[10:8]];
    end else if (f[15:9] == TLS_ENC_PUSH) begin
      d.op   = TLS_OP_PUSH;
      d.rn   = TLS_SP_IDX;
      d.mask = f[8:0];
      d.wb   = 1'b1;
    end else if (f[15:9] == TLS_ENC_POP) begin
      d.op   = TLS_OP_POP;
      d.load = 1'b1;
      d.rn   = TLS_SP_IDX;
      d.mask = f[8:0];
      d.wb   = 1'b1;
    end
    // an empty list does nothing; legal code never gives one
    if (d.op inside {TLS_OP_MULTI, TLS_OP_PUSH, TLS_OP_POP}
        && d.mask == '0) begin
      d.op = TLS_OP_NONE;
    end
    return d;
  endfunction : decode

  // ****************************************************************
  // state
  // ****************************************************************
  tls_state_type         state_q;
  tls_dec_type           dec_q;
  tls_dec_type           dec_w;
  logic [31:0]           base_q;
  logic [31:0]           off_q;
  logic [31:0]           addr_q;
  logic [31:0]           wb_val_q;
  logic [TLS_LIST_W-1:0] rem_q;
  logic [TLS_LIST_W-1:0] rem_next;
  logic [3:0]            cur_idx_q;
  logic [31:0]           pc_val_q;
  logic                  pc_hit_q;
  logic                  is_list;
  logic [31:0]           list_span;
  logic [31:0]           list_start;
  logic [31:0]           agu_base;
  logic [31:0]           agu_off;
  logic [31:0]           agu_addr;
  logic                  agu_bad;
  logic [31:0]           st_data;
  logic [31:0]           ld_data;
  logic                  acked;
  logic                  more;

  assign dec_w      = decode(instr);
  assign is_list    = dec_q.op inside {TLS_OP_MULTI, TLS_OP_PUSH,
                                       TLS_OP_POP};
  assign list_span  = {26'h0000000, count_regs(dec_q.mask), 2'h0};
  assign list_start = (dec_q.op == TLS_OP_PUSH)
                      ? base_q - list_span : base_q;
  assign agu_base   = is_list ? list_start : base_q;
  assign agu_off    = is_list ? 32'h0 : off_q;
  assign rem_next   = rem_q & (rem_q - 1'b1);
  assign acked      = state_q == ST_MEM && mem_ack;
  assign more       = is_list && rem_next != '0;

  tls_agu_ext u_agu (
    .base       (agu_base),
    .offset     (agu_off),
    .size       (dec_q.size),
    .sgn        (dec_q.sgn),
    .addr       (agu_addr),
    .misaligned (agu_bad),
    .store_src  (reg_rd_data),
    .load_raw   (mem_rdata),
    .store_data (st_data),
    .load_data  (ld_data)
  );

  // ****************************************************************
  // sequencing
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q    <= ST_IDLE;
      dec_q      <= '0;
      base_q     <= 32'h0;
      off_q      <= 32'h0;
      addr_q     <= 32'h0;
      wb_val_q   <= 32'h0;
      rem_q      <= '0;
      reg_rd_idx <= 4'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (instr_valid) begin
            dec_q <= dec_w;
            if (dec_w.op == TLS_OP_LIT) begin
              base_q  <= (instr_pc + TLS_PC_AHEAD) & ~32'h3;
              off_q   <= dec_w.imm;
              state_q <= ST_ADDR;
            end else if (dec_w.op != TLS_OP_NONE) begin
              reg_rd_idx <= dec_w.rn;
              state_q    <= ST_BASE;
            end
          end
        end
        ST_BASE: begin
          base_q <= reg_rd_data;
          if (dec_q.regoff) begin
            reg_rd_idx <= {1'b0, dec_q.rm};
            state_q    <= ST_OFF;
          end else begin
            off_q   <= dec_q.imm;
            state_q <= ST_ADDR;
          end
        end
        ST_OFF: begin
          off_q   <= reg_rd_data;
          state_q <= ST_ADDR;
        end
        ST_ADDR: begin
          addr_q   <= agu_addr;
          // push ends on the lowest address, the others above the top
          wb_val_q <= (dec_q.op == TLS_OP_PUSH)
                      ? list_start : base_q + list_span;
          rem_q    <= dec_q.mask;
          if (agu_bad) begin
            state_q <= ST_IDLE;
          end else begin
            reg_rd_idx <= is_list ? first_reg(dec_q.mask, dec_q.op)
                                  : {1'b0, dec_q.rt};
            state_q    <= ST_DATA;
          end
        end
        ST_DATA: begin
          state_q <= ST_MEM;
        end
        ST_MEM: begin
          if (mem_ack) begin
            rem_q <= rem_next;
            if (more) begin
              addr_q     <= addr_q + TLS_WORD_BYTES;
              reg_rd_idx <= first_reg(rem_next, dec_q.op);
              state_q    <= ST_DATA;
            end else begin
              state_q <= ST_WB;
            end
          end
        end
        ST_WB: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // memory bus
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem       <= '0;
      cur_idx_q <= 4'h0;
    end else if (state_q == ST_DATA) begin
      mem.req   <= 1'b1;
      mem.write <= !dec_q.load;
      mem.size  <= dec_q.size;
      mem.addr  <= addr_q;
      mem.wdata <= dec_q.load ? 32'h0 : st_data;
      cur_idx_q <= reg_rd_idx;
    end else if (acked) begin
      mem.req <= 1'b0;
    end
  end

  // ****************************************************************
  // register write-back
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_wr <= '0;
    end else if (acked && dec_q.load && cur_idx_q != TLS_PC_IDX) begin
      reg_wr.en   <= 1'b1;
      reg_wr.idx  <= cur_idx_q;
      reg_wr.data <= ld_data;
    end else if (state_q == ST_WB && is_list && dec_q.wb) begin
      reg_wr.en   <= 1'b1;
      reg_wr.idx  <= dec_q.rn;
      reg_wr.data <= wb_val_q;
    end else begin
      reg_wr.en <= 1'b0;
    end
  end

  // ****************************************************************
  // branch on pop of the program counter
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_hit_q <= 1'b0;
      pc_val_q <= 32'h0;
      branch   <= '0;
    end else begin
      if (acked && dec_q.load && cur_idx_q == TLS_PC_IDX) begin
        pc_hit_q <= 1'b1;
        pc_val_q <= mem_rdata;
      end else if (state_q == ST_WB) begin
        pc_hit_q <= 1'b0;
      end
      // taken only at the end of the pop, in the same cycle as the sp update
      branch.en     <= state_q == ST_WB && pc_hit_q;
      branch.target <= {pc_val_q[31:1], 1'b0};
      branch.tbit   <= pc_val_q[0];
    end
  end

  // ****************************************************************
  // handshake with the instruction stream
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      instr_ready <= 1'b1;
      done        <= 1'b0;
      fault       <= 1'b0;
      flags_wr_en <= 1'b0;
    end else begin
      instr_ready <= (state_q == ST_IDLE && !instr_valid)
                     || (state_q == ST_IDLE && dec_w.op == TLS_OP_NONE)
                     || state_q == ST_WB
                     || (state_q == ST_ADDR && agu_bad);
      done        <= state_q == ST_WB
                     || (state_q == ST_IDLE && instr_valid
                         && dec_w.op == TLS_OP_NONE);
      fault       <= state_q == ST_ADDR && agu_bad;
      flags_wr_en <= 1'b0;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_ack_more;
    mem.req && mem_ack && more;
  endsequence

  sequence s_next_word;
    ##2 mem.req && mem.addr == $past(mem.addr, 2) + TLS_WORD_BYTES;
  endsequence

  property p_byte_store;
    @(posedge clk) disable iff (rst)
      mem.req && mem.write && mem.size == TLS_SZ_BYTE
      |-> mem.wdata[31:8] == 24'h0;
  endproperty
  a_byte_store: assert property (p_byte_store)
    else $error("byte store drives upper lanes");

  property p_aligned;
    @(posedge clk) disable iff (rst)
      mem.req |-> (mem.size == TLS_SZ_BYTE)
               || (mem.size == TLS_SZ_HALF && !mem.addr[0])
               || (mem.size == TLS_SZ_WORD && mem.addr[1:0] == 2'h0);
  endproperty
  a_aligned: assert property (p_aligned)
    else $error("unaligned access reached the bus");

  property p_fault;
    @(posedge clk) disable iff (rst)
      fault |-> !mem.req ##1 !mem.req;
  endproperty
  a_fault: assert property (p_fault)
    else $error("access issued on fault");

  property p_flags;
    @(posedge clk) disable iff (rst)
      done |-> !flags_wr_en && !$past(flags_wr_en);
  endproperty
  a_flags: assert property (p_flags)
    else $error("flags written by a transfer");

  property p_hold;
    @(posedge clk) disable iff (rst)
      mem.req && !mem_ack |=> mem.req && $stable(mem.addr)
                              && $stable(mem.write) && $stable(mem.size);
  endproperty
  a_hold: assert property (p_hold)
    else $error("request changed before acknowledge");

  property p_next_word;
    @(posedge clk) disable iff (rst)
      s_ack_more |-> s_next_word;
  endproperty
  a_next_word: assert property (p_next_word)
    else $error("next list word not four bytes higher");

  property p_pop_sp;
    @(posedge clk) disable iff (rst)
      state_q == ST_WB && dec_q.op == TLS_OP_POP
      |=> reg_wr.en && reg_wr.idx == TLS_SP_IDX
          && reg_wr.data == $past(mem.addr) + TLS_WORD_BYTES;
  endproperty
  a_pop_sp: assert property (p_pop_sp)
    else $error("sp after pop not above top word");

  property p_no_wb;
    @(posedge clk) disable iff (rst)
      state_q == ST_WB && dec_q.op == TLS_OP_MULTI && dec_q.load
      && dec_q.mask[dec_q.rn[2:0]] |=> !reg_wr.en;
  endproperty
  a_no_wb: assert property (p_no_wb)
    else $error("writeback despite base in load list");

  property p_sext;
    @(posedge clk) disable iff (rst)
      acked && dec_q.op == TLS_OP_SINGLE && dec_q.sgn
      && dec_q.size == TLS_SZ_BYTE
      |=> reg_wr.en && reg_wr.data == {{24{$past(mem_rdata[7])}},
                                       $past(mem_rdata[7:0])};
  endproperty
  a_sext: assert property (p_sext)
    else $error("signed byte load badly extended");

  property p_pc_branch;
    @(posedge clk) disable iff (rst)
      branch.en |-> !reg_wr.en || reg_wr.idx != TLS_PC_IDX
                    ##0 $past(state_q) == ST_WB;
  endproperty
  a_pc_branch: assert property (p_pc_branch)
    else $error("branch not at end of pop");

endmodule : tls_unit

// file: sim/tls_mem_model.sv
`timescale 1ns/1ps
// ********
// memory slave with random wait states
// ********
module tls_mem_model (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // memory bus
  input  wire tls_pkg::tls_mem_req_type mem,
  output logic                          mem_ack,
  output logic [31:0]                   mem_rdata
);
  import tls_pkg::*;
  logic [7:0]  bytes_q [0:2047];
  logic [31:0] n_acc_q;
  logic [10:0] a;
  int          wait_q;
  assign a = mem.addr[10:0];
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 32'h0;
      wait_q    <= 0;
      n_acc_q   <= 32'h0;
    end else if (mem_ack) begin
      // one ack per request; released data never repeats the last value
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (mem.req && wait_q == 0) begin
      mem_ack   <= 1'b1;
      mem_rdata <= {bytes_q[a + 11'h3], bytes_q[a + 11'h2],
                    bytes_q[a + 11'h1], bytes_q[a]}
                   & ~(32'hffffffff << (8 << mem.size));
      n_acc_q   <= n_acc_q + 32'h1;
      wait_q    <= $urandom_range(5);
      for (int i = 0; i < 4; i++) begin
        if (mem.write && i < (1 << mem.size)) begin
          bytes_q[a + 11'(i)] <= mem.wdata[i*8 +: 8];
        end
      end
    end else if (mem.req) begin
      wait_q    <= wait_q - 1;
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : tls_mem_model

// file: sim/thumb_load_store_unit_tb_top.sv
`timescale 1ns/1ps
module thumb_load_store_unit_tb_top;
  import tls_pkg::*;
  logic clk = 1'b0, rst = 1'b1, instr_valid = 1'b0, instr_ready, done, fault;
  logic flags_wr_en, mem_ack, flag_seen = 1'b0, got_fault;
  logic [15:0] instr = 16'h0;
  logic [31:0] instr_pc = 32'h0, mem_rdata, br_q, b, a, v, r, o;
  logic [31:0] rf [0:15];
  logic [3:0]  reg_rd_idx;
  logic [7:0]  fld;
  logic [2:0]  rt, rn;
  tls_reg_wr_type  reg_wr;
  tls_branch_type  branch;
  tls_mem_req_type mem;
  tls_size_type    sz;
  tls_size_type    szt [8] = '{TLS_SZ_WORD, TLS_SZ_HALF, TLS_SZ_BYTE,
    TLS_SZ_BYTE, TLS_SZ_WORD, TLS_SZ_HALF, TLS_SZ_BYTE, TLS_SZ_HALF};
  logic [4:0] op5 [4] = '{5'h0c, 5'h12, 5'h10, 5'h0e};
  int miscompares = 0, num_checks = 0;
  tls_unit dut (.clk(clk), .rst(rst), .instr_valid(instr_valid),
    .instr(instr), .instr_pc(instr_pc), .instr_ready(instr_ready),
    .done(done), .fault(fault), .reg_rd_idx(reg_rd_idx),
    .reg_rd_data(rf[reg_rd_idx]), .reg_wr(reg_wr), .branch(branch),
    .flags_wr_en(flags_wr_en), .mem(mem), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  tls_mem_model u_mem (.clk(clk), .rst(rst), .mem(mem), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (reg_wr.en === 1'b1) rf[reg_wr.idx] <= reg_wr.data;
    if (branch.en === 1'b1) br_q <= {branch.target[31:1], branch.tbit};
    if (!rst && flags_wr_en !== 1'b0) flag_seen <= 1'b1;
  end
  function automatic logic [31:0] msk(input tls_size_type s);
    return ~(32'hffffffff << (8 << s));
  endfunction : msk
  function automatic logic [31:0] peek(input logic [31:0] p);
    return {u_mem.bytes_q[p[10:0] + 11'h3], u_mem.bytes_q[p[10:0] + 11'h2],
            u_mem.bytes_q[p[10:0] + 11'h1], u_mem.bytes_q[p[10:0]]};
  endfunction : peek
  task automatic poke(input logic [31:0] p, input logic [31:0] w);
    for (int i = 0; i < 4; i++) u_mem.bytes_q[p[10:0] + 11'(i)] = w[i*8 +: 8];
  endtask : poke
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  // one instruction; waits bounded for done or fault, then lets writes land
  task automatic run(input logic [15:0] ins, input logic [31:0] pc);
    int n;
    check({31'h0, instr_ready}, 32'h1);
    instr_valid <= 1'b1;
    instr       <= ins;
    instr_pc    <= pc;
    @(posedge clk);
    instr_valid <= 1'b0;
    for (n = 0; n < 300 && done !== 1'b1 && fault !== 1'b1; n++)
      @(posedge clk);
    got_fault = (fault === 1'b1);
    if (n == 300) begin
      miscompares++;
      stop_test();
    end
    @(posedge clk);
  endtask : run
  initial begin
    void'($urandom(32'he1913e53));
    for (int i = 0; i < 16; i++) rf[i] = 32'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // immediate offsets: low-base word, sp word, halfword, byte; max first
    for (int i = 0; i < 24; i++) begin
      rt = 3'($urandom_range(7));
      rn = rt + 3'($urandom_range(7, 1));
      fld = (i < 4) ? 8'hff : 8'($urandom);
      if (i % 4 != 1) fld = fld & 8'h1f;
      sz = (i % 4 < 2) ? TLS_SZ_WORD
         : (i % 4 == 2) ? TLS_SZ_HALF : TLS_SZ_BYTE;
      b = 32'h100 + 4 * $urandom_range(60);
      a = b + ({24'h0, fld} << sz);
      if (i % 4 == 1) rf[13] = b;
      else rf[rn] = b;
      v = $urandom;
      rf[rt] = v;
      poke(a, 32'h5a5a5a5a);
      run((i % 4 == 1) ? {5'h12, rt, fld} : {op5[i % 4], fld[4:0], rn, rt}, 0);
      check(peek(a), (32'h5a5a5a5a & ~msk(sz)) | (v & msk(sz)));
      rf[rt] = ~v;
      run((i % 4 == 1) ? {5'h13, rt, fld}
                       : {op5[i % 4] | 5'h1, fld[4:0], rn, rt}, 0);
      check(rf[rt], v & msk(sz));
    end
    $display("test immediate done");
    // register offsets: every store and load variant
    for (int k = 0; k < 8; k++) begin
      sz = szt[k];
      b = 32'h100 + 4 * $urandom_range(60);
      o = $urandom_range(20) << sz;
      r = $urandom;
      v = $urandom;
      rf[4] = b;
      rf[5] = o;
      rf[3] = v;
      poke(b + o, r);
      run({4'h5, 3'(k), 3'd5, 3'd4, 3'd3}, 0);
      if (k < 3) check(peek(b + o), (r & ~msk(sz)) | (v & msk(sz)));
      else if (k == 3 || k == 7) check(rf[3], (sz == TLS_SZ_BYTE) ?
        {{24{r[7]}}, r[7:0]} : {{16{r[15]}}, r[15:0]});
      else check(rf[3], r & msk(sz));
    end
    // unaligned word and halfword loads fault with no access made
    for (int k = 0; k < 2; k++) begin
      rf[5] = 32'h1 << (1 - k);
      v = $urandom;
      rf[3] = v;
      o = u_mem.n_acc_q;
      run({4'h5, 3'(4 + k), 3'd5, 3'd4, 3'd3}, 0);
      check({31'h0, got_fault}, 32'h1);
      check(u_mem.n_acc_q, o);
      check(rf[3], v);
    end
    $display("test register offset done");
    for (int i = 0; i < 4; i++) begin
      o = 2 * $urandom_range(200);
      fld = (i == 0) ? 8'hff : 8'($urandom);
      a = ((o + 32'h4) & ~32'h3) + {22'h0, fld, 2'h0};
      v = $urandom;
      poke(a, v);
      rf[2] = ~v;
      run({5'h09, 3'd2, fld}, o);
      check(rf[2], v);
    end
    $display("test literal done");
    // base listed first in the store; load list holds its base
    b = 32'h300;
    rf[0] = b;
    rf[2] = $urandom;
    rf[5] = $urandom;
    run(16'hc025, 0);
    check(peek(b), b);
    check(peek(b + 4), rf[2]);
    check(peek(b + 8), rf[5]);
    check(rf[0], b + 32'hc);
    rf[6] = b;
    run(16'hcec8, 0);
    check(rf[7], rf[5]);
    check(rf[6], rf[2]);
    rf[1] = b;
    run(16'hc914, 0);
    check(rf[1], b + 32'h8);
    $display("test multiple done");
    rf[13] = 32'h400;
    rf[14] = $urandom | 32'h1;
    rf[1] = $urandom;
    run(16'hb503, 0);
    check(peek(32'h3fc), rf[14]);
    check(rf[13], 32'h3f4);
    run(16'hbd0c, 0);
    check(rf[3], rf[1]);
    check(rf[13], 32'h400);
    check(br_q, rf[14]);
    // a word outside the group only finishes: no access, no fault
    o = u_mem.n_acc_q;
    run(16'h0000, 0);
    check(u_mem.n_acc_q, o);
    check({31'h0, got_fault}, 32'h0);
    check({31'h0, flag_seen}, 32'h0);
    $display("test stack done");
    stop_test();
  end
endmodule : thumb_load_store_unit_tb_top
